// >>> vst_pkg.sv
// Purpose: shared constants and types for the vme short-address slave front end
// Assumes: ref_clk at 200 MHz, vme sysclk at 16 MHz arriving as a sampled input
// Notes:   timing minima are rounded up to whole clock counts
`default_nettype none

package vst_pkg;

    // ------------------------------------------------------------
    // clock rates and printed times
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS    = 5000;   // ref_clk period
    localparam int unsigned SYSCLK_PERIOD_PS = 62500;  // 16 MHz vme sysclk period
    localparam int unsigned AS_DLY_NS        = 25;     // address strobe delay before decode capture
    localparam int unsigned T_SETUP_NS       = 85;     // chip address set-up before strobes
    localparam int unsigned T_ACCESS_NS      = 250;    // read access / write data set-up
    localparam int unsigned T_RECOV_NS       = 250;    // recovery after each access

    // ref_clk counts, least times rounded up
    localparam int unsigned AS_DLY_CYC = (AS_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SETUP_CYC  = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned ACCESS_CYC = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // sysclk edge counts; one extra edge because the first sampled edge may come at once
    localparam logic [2:0] SETUP_EDGES  = 3'((T_SETUP_NS * 1000 + SYSCLK_PERIOD_PS - 1) / SYSCLK_PERIOD_PS + 1);
    localparam logic [2:0] ACCESS_EDGES = 3'((T_ACCESS_NS * 1000 + SYSCLK_PERIOD_PS - 1) / SYSCLK_PERIOD_PS + 1);
    localparam logic [2:0] RECOV_EDGES  = 3'((T_RECOV_NS * 1000 + SYSCLK_PERIOD_PS - 1) / SYSCLK_PERIOD_PS + 1);
    localparam logic [2:0] AS_DLY_LAST  = 3'(AS_DLY_CYC - 1);
    localparam logic [2:0] TMR_MAX      = 3'h7;
    localparam logic [7:0] AGE_MAX      = 8'hFF;

    // ------------------------------------------------------------
    // decode codes and data fill
    // ------------------------------------------------------------
    localparam logic [5:0] AM_SUPV    = 6'h29;  // short supervisory access
    localparam logic [5:0] AM_NONPRIV = 6'h2D;  // short non-privileged access
    localparam logic [7:0] UPPER_FILL = 8'hFF;  // upper byte returned on reads

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] BG_RST  = 4'hF;
    localparam logic [7:1] IRQ_RST = 7'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:1] addr;     // address lines a15..a01
        logic [5:0]  am;       // address modifier
        logic        lword_n;  // long word select, low true
        logic        iack_n;   // interrupt acknowledge, low true
    } vst_addr_type;

    typedef struct packed {
        logic as_n;     // address strobe
        logic ds0_n;    // data strobe, odd byte
        logic ds1_n;    // data strobe, even byte
        logic write_n;  // low on write cycles
        logic dtack_n;  // dtack level seen on the bus
    } vst_strobe_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_READ,
        ST_RD_ACK,
        ST_WRITE,
        ST_WR_ACK,
        ST_RECOVER
    } vst_state_type;

endpackage

`default_nettype wire

// >>> vst_vme_slave.sv
// Purpose: vme slave access timing for an on-board gpib talker/listener/controller
// Assumes: ref_clk 200 MHz; vme strobes asynchronous; address lines stable while strobed
// Notes:   interrupter logic lives outside and reaches us via vector_enable and
//          intr_ack_request_n; bus grants pass through one register stage
//
// Operation
// - transceiver on when vector or transfer enabled
// - transceiver points to bus on read/vector
// - dtack follows requests, released after strobes high
// - wait for foreign dtack release first
// - open-collector dtack and irq, active iackout
// - bus grants 0-3 passed through one register stage
// - latch a01-a03 unless still driving dtack
// - 16-byte window compared on a04-a15
// - accept only matching base, am, lword, iack
// - latch decode on delayed strobe; else idle
// - ignore ds1; upper byte ff/discarded
// - clear match when address strobe released
// - no ds0 means address-only, no action
// - time from sysclk, chip clock sysclk/2
// - system reset clears chip and machine
// - start at least 85 ns after ds0
// - read strobe at once, ack after 250 ns
// - read held until ds0 released, then recover
// - write strobe 250 ns, then ack
// - write ack held until both strobes released
// - 250 ns recovery, new access held off
// - chip registers at odd bytes, a1-a3 select
`default_nettype none

module vst_vme_slave (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  sysclk_16m,
    input  wire vst_pkg::vst_addr_type vme_adr,
    input  wire vst_pkg::vst_strobe_type vme_strb,
    input  wire logic [15:0]           vme_d_in,
    output logic [15:0]                vme_d_out,
    output logic                       vme_d_oe,
    output logic                       dtack_o,
    output logic                       dtack_oe,
    input  wire logic [7:1]            irq_req,
    output logic [7:1]                 irq_o,
    output logic [7:1]                 irq_oe,
    input  wire logic                  iackout_req_n,
    output logic                       iackout_n,
    input  wire logic [3:0]            bg_in_n,
    output logic [3:0]                 bg_out_n,
    input  wire logic [11:0]           base_sw,
    input  wire logic                  am_nonpriv_sel,
    input  wire logic                  vector_enable,
    input  wire logic                  intr_ack_request_n,
    input  wire logic [7:0]            chip_rdata,
    output logic [7:0]                 chip_wdata,
    output logic [2:0]                 chip_rs,
    output logic                       chip_cs_n,
    output logic                       periph_read_strobe_n,
    output logic                       periph_write_strobe_n,
    output logic                       data_driver_enable_n,
    output logic                       xcvr_en,
    output logic                       xcvr_to_vme,
    output logic                       chip_clk,
    output logic                       chip_reset,
    output logic                       access_start,
    output logic                       addr_match_latched
);
    import vst_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    vst_strobe_type sync1_q;        // first synchroniser stage, read only by sync2_q
    vst_strobe_type sync2_q;        // settled strobes
    logic           sys1_q;         // sysclk first stage
    logic           sys2_q;         // sysclk settled
    logic           sys_prev_q;     // sysclk previous sample for edge detect
    logic           sys_edge;       // one ref cycle per sysclk rise
    logic [2:0]     as_cnt_q;       // address strobe delay counter
    logic           as_dly_pulse;   // delayed address strobe event
    logic           addr_hit;       // combinational window decode
    logic           rs_taken_q;     // register select captured for this strobe
    vst_state_type  state_q;        // access state
    vst_state_type  state_d;
    logic [2:0]     tmr_q;          // sysclk edges in current state
    logic           rw_ack_request_n_q;
    logic           foreign_dtack;  // someone else holds dtack
    logic           rd_phase_d;     // next state is a read data phase
    logic           den_d;          // next data driver enable, low true
    logic [7:0]     ds0_age_q;      // ref cycles ds0 held, assertion helper
    logic [7:0]     acc_age_q;      // ref cycles since access start, assertion helper

    assign sys_edge      = sys2_q & ~sys_prev_q;
    assign as_dly_pulse  = ~sync2_q.as_n && (as_cnt_q == AS_DLY_LAST);
    assign foreign_dtack = ~sync2_q.dtack_n && ~dtack_oe;
    assign rd_phase_d    = (state_d == ST_READ) || (state_d == ST_RD_ACK);
    assign den_d         = ~((state_d == ST_READ) || (state_d == ST_RD_ACK) ||
                             (state_d == ST_WRITE) || (state_d == ST_WR_ACK));

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    // two stages on every asynchronous strobe and on sysclk
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_q    <= '1;
            sync2_q    <= '1;
            sys1_q     <= 1'b0;
            sys2_q     <= 1'b0;
            sys_prev_q <= 1'b0;
        end else begin
            sync1_q    <= vme_strb;
            sync2_q    <= sync1_q;
            sys1_q     <= sysclk_16m;
            sys2_q     <= sys1_q;
            sys_prev_q <= sys2_q;
        end
    end

    // chip clock: toggles on every sysclk rise, so half the sysclk rate
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            chip_clk <= 1'b0;
        end else if (sys_edge) begin
            chip_clk <= ~chip_clk;
        end
    end

    // chip reset mirrors system reset one cycle late
    always_ff @(posedge ref_clk) begin
        chip_reset <= rst;
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // byte-wide window; ds1 plays no part in sizing
    always_comb begin
        addr_hit = (vme_adr.addr[15:4] == base_sw) &&
                   (vme_adr.am == (am_nonpriv_sel ? AM_NONPRIV : AM_SUPV)) &&
                   vme_adr.lword_n && vme_adr.iack_n;
    end

    // delayed address strobe; stops once it has fired
    always_ff @(posedge ref_clk) begin
        if (rst || sync2_q.as_n) begin
            as_cnt_q <= 3'h0;
        end else if (as_cnt_q != 3'(AS_DLY_CYC)) begin
            as_cnt_q <= as_cnt_q + 3'h1;
        end
    end

    // match flag: caught on delayed strobe, dropped when strobe released
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_match_latched <= 1'b0;
        end else if (sync2_q.as_n) begin
            addr_match_latched <= 1'b0;
        end else if (as_dly_pulse) begin
            addr_match_latched <= addr_hit;
        end
    end

    // register select: a pipelined address waits until our dtack is gone,
    // so the chip never sees its select move under an active access
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            chip_rs    <= 3'h0;
            rs_taken_q <= 1'b0;
        end else if (sync2_q.as_n) begin
            rs_taken_q <= 1'b0;
        end else if (!rs_taken_q && !dtack_oe) begin
            chip_rs    <= vme_adr.addr[3:1];
            rs_taken_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // access state machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // a cycle with no ds0 never leaves idle
                if (addr_match_latched && !sync2_q.ds0_n && !foreign_dtack) begin
                    state_d = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (sync2_q.ds0_n) begin
                    state_d = ST_IDLE;
                end else if (tmr_q >= SETUP_EDGES) begin
                    state_d = sync2_q.write_n ? ST_READ : ST_WRITE;
                end
            end
            ST_READ: begin
                if (tmr_q >= ACCESS_EDGES) begin
                    state_d = ST_RD_ACK;
                end
            end
            ST_RD_ACK: begin
                if (sync2_q.ds0_n) begin
                    state_d = ST_RECOVER;
                end
            end
            ST_WRITE: begin
                if (tmr_q >= ACCESS_EDGES) begin
                    state_d = ST_WR_ACK;
                end
            end
            ST_WR_ACK: begin
                if (sync2_q.ds0_n && sync2_q.ds1_n) begin
                    state_d = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                // recovery counts only once dtack is off the bus
                if (!dtack_oe && tmr_q >= RECOV_EDGES) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // edge timer: restarts on every state change and while dtack is held in recovery
    always_ff @(posedge ref_clk) begin
        if (rst || state_d != state_q || (state_q == ST_RECOVER && dtack_oe)) begin
            tmr_q <= 3'h0;
        end else if (sys_edge && tmr_q != TMR_MAX) begin
            tmr_q <= tmr_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // chip strobes and acknowledge request
    // ------------------------------------------------------------
    // registered from the next state so strobes rise with the state itself
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            access_start          <= 1'b0;
            periph_read_strobe_n  <= 1'b1;
            periph_write_strobe_n <= 1'b1;
            chip_cs_n             <= 1'b1;
            data_driver_enable_n  <= 1'b1;
            rw_ack_request_n_q    <= 1'b1;
        end else begin
            access_start          <= (state_q == ST_SETUP) && (state_d != ST_SETUP) &&
                                     (state_d != ST_IDLE);
            periph_read_strobe_n  <= ~rd_phase_d;
            periph_write_strobe_n <= ~(state_d == ST_WRITE);
            chip_cs_n             <= ~(rd_phase_d || state_d == ST_WRITE);
            data_driver_enable_n  <= den_d;
            rw_ack_request_n_q    <= ~((state_d == ST_RD_ACK) || (state_d == ST_WR_ACK));
        end
    end

    // ------------------------------------------------------------
    // dtack drive and transceiver
    // ------------------------------------------------------------
    // a new request wins over a release in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dtack_oe <= 1'b0;
        end else if (!rw_ack_request_n_q || !intr_ack_request_n) begin
            dtack_oe <= 1'b1;
        end else if (data_driver_enable_n && sync2_q.ds0_n && sync2_q.ds1_n) begin
            dtack_oe <= 1'b0;
        end
    end

    // open-collector level is always low; only the enable moves
    always_ff @(posedge ref_clk) begin
        dtack_o <= 1'b0;
        irq_o   <= IRQ_RST;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xcvr_en     <= 1'b0;
            xcvr_to_vme <= 1'b0;
            vme_d_oe    <= 1'b0;
            vme_d_out   <= {UPPER_FILL, 8'h00};
            chip_wdata  <= 8'h00;
        end else begin
            xcvr_en     <= vector_enable || !den_d;
            xcvr_to_vme <= vector_enable || rd_phase_d;
            vme_d_oe    <= rd_phase_d;
            vme_d_out   <= {UPPER_FILL, chip_rdata};
            chip_wdata  <= vme_d_in[7:0];
        end
    end

    // ------------------------------------------------------------
    // pass-through lines
    // ------------------------------------------------------------
    // one register stage; grants must not be held by this board
    genvar gi;
    for (gi = 1; gi <= 7; gi++) begin : g_pass
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                irq_oe[gi] <= 1'b0;
            end else begin
                irq_oe[gi] <= irq_req[gi];
            end
        end
        if (gi <= 4) begin : g_bg
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    bg_out_n[gi-1] <= BG_RST[gi-1];
                end else begin
                    bg_out_n[gi-1] <= bg_in_n[gi-1];
                end
            end
        end
    end

    // iackout driven actively from the interrupter request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            iackout_n <= 1'b1;
        end else begin
            iackout_n <= iackout_req_n;
        end
    end

    // ------------------------------------------------------------
    // assertion helpers and checks
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst || sync2_q.ds0_n) begin
            ds0_age_q <= 8'h00;
        end else if (ds0_age_q != AGE_MAX) begin
            ds0_age_q <= ds0_age_q + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || access_start) begin
            acc_age_q <= 8'h00;
        end else if (acc_age_q != AGE_MAX) begin
            acc_age_q <= acc_age_q + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_dtack_assert: assert property ((!rw_ack_request_n_q || !intr_ack_request_n) |=> dtack_oe)
        else $error("dtack not driven after acknowledge request");
    a_dtack_hold: assert property (dtack_oe && (!sync2_q.ds0_n || !sync2_q.ds1_n) |=> dtack_oe)
        else $error("dtack released while a data strobe is low");
    a_start_setup: assert property (access_start |-> ds0_age_q >= 8'(SETUP_CYC))
        else $error("access started before address set-up elapsed");
    a_ack_delay: assert property ($fell(rw_ack_request_n_q) |-> acc_age_q >= 8'(ACCESS_CYC))
        else $error("acknowledge requested before access time");
    a_match_clear: assert property (sync2_q.as_n |=> !addr_match_latched)
        else $error("match flag survived strobe release");
    a_start_matched: assert property (access_start |-> $past(addr_match_latched, 2))
        else $error("access started without a latched match");
    a_foreign_wait: assert property ((state_q == ST_SETUP) && ($past(state_q) == ST_IDLE)
                                     |-> $past(sync2_q.dtack_n || dtack_oe))
        else $error("access begun while another module held dtack");
    a_write_end: assert property ($rose(periph_write_strobe_n) && !chip_reset |-> !rw_ack_request_n_q)
        else $error("write strobe ended without acknowledge request");
    a_grant_pass: assert property (##1 bg_out_n == $past(bg_in_n))
        else $error("bus grant not passed through");

    c_read: cover property ((state_q == ST_RD_ACK) ##[1:200] (state_q == ST_RECOVER));
    c_write: cover property ((state_q == ST_WR_ACK) ##[1:200] (state_q == ST_RECOVER));
    c_addr_only: cover property ($rose(addr_match_latched) ##[1:100] $fell(addr_match_latched));

endmodule

`default_nettype wire

// >>> vst_master_model.sv
// Purpose: vme master stand-in making short byte cycles
// Assumes: dtack is wired-or with a backplane pull-up
// Notes:   released lines show the inverse of their last value
`default_nettype none
module vst_master_model
    import vst_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               dtack_oe,
    input  wire logic               fdtack,
    input  wire logic [15:0]        d_out,
    output vst_pkg::vst_addr_type   adr,
    output vst_pkg::vst_strobe_type strb,
    output logic [15:0]             d_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic as_n  = 1'b1;  // strobes idle high
    logic ds0_n = 1'b1;
    logic ds1_n = 1'b1;
    logic wr_n  = 1'b1;
    initial adr = '0;
    initial d_in = '0;
    // bus dtack is low while anyone pulls it
    assign strb = '{as_n, ds0_n, ds1_n, wr_n, ~(dtack_oe | fdtack)};
    // address, direction and strobes launched together; ds high asks for data
    task automatic go(input logic [15:1] a, input logic [5:0] am, input logic lw_n,
                      input logic ia_n, input logic wr, input logic ds);
        @(posedge ref_clk);
        #1;
        adr = '{a, am, lw_n, ia_n};
        wr_n = ~wr;
        d_in = 16'h5AC3;
        as_n = 1'b0;
        ds0_n = ~ds;
        ds1_n = 1'b0;
    endtask
    // dtack looked for at rising edges; read data taken at that same edge
    task automatic ack(input int lim, output logic seen, output logic [15:0] rd);
        seen = 1'b0;
        rd = '0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge ref_clk);
            seen = ~strb.dtack_n;
            rd = d_out;
        end
    endtask
    // ds0 first, ds1 after a lag, then lines float and dtack release is awaited
    task automatic stop(input int lag);
        #1;
        ds0_n = 1'b1;
        repeat (lag) @(posedge ref_clk);
        if (lag > 0) #1;
        ds1_n = 1'b1;
        as_n = 1'b1;
        adr = ~adr;
        d_in = ~d_in;
        for (int i = 0; i < 100 && strb.dtack_n !== 1'b1; i++) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// >>> vme_slave_access_timing_test.sv
// Purpose: self-checking bench for the vme slave access timing
// Assumes: 200 MHz ref_clk, 16 MHz sysclk drifting against it
// Notes:   one task per scenario; timing judged in ns
`default_nettype none
module vme_slave_access_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    import vst_pkg::*;
    logic           ref_clk = 1'b0;
    logic           sysclk  = 1'b0;
    logic           rst     = 1'b1;
    logic           fdtack  = 1'b0;  // another slave holding dtack
    logic           vec_en  = 1'b0;
    logic           iack_n  = 1'b1;
    logic           npriv   = 1'b0;
    logic [3:0]     bg_in_n = 4'hF;
    logic [7:1]     irq_req = 7'h00;
    logic [7:0]     rdata   = 8'h96;  // chip register content
    vst_addr_type   adr;
    vst_strobe_type strb;
    logic [15:0]    d_in, d_out;
    logic [7:1]     irq_o, irq_oe;
    logic [3:0]     bg_out_n;
    logic [7:0]     wdata;
    logic [2:0]     rs;
    logic           dt_o, dt_oe, rd_n, wr_n, xen, xdir, cclk, creset, start, match;
    logic           iko_n   = 1'b1;  // interrupter asks to pass the acknowledge on
    logic           iko, d_oe, cs_n, den_n;
    realtime        t_go, t_ack, t_rel, t_ds, t_free;
    int             err_total = 0;
    int             cmp_count = 0;
    always #2.5 ref_clk = ~ref_clk;
    always #31.25 sysclk = ~sysclk;
    // event times for the timing checks
    always @(posedge start) t_go = $realtime;
    always @(posedge dt_oe) t_ack = $realtime;
    always @(negedge dt_oe) t_rel = $realtime;
    always @(negedge strb.ds0_n) t_ds = $realtime;
    vst_vme_slave i_dut (.ref_clk(ref_clk), .rst(rst), .sysclk_16m(sysclk), .vme_adr(adr), .vme_strb(strb),
        .vme_d_in(d_in), .vme_d_out(d_out), .vme_d_oe(d_oe), .dtack_o(dt_o), .dtack_oe(dt_oe), .irq_req(irq_req),
        .irq_o(irq_o), .irq_oe(irq_oe), .iackout_req_n(iko_n), .iackout_n(iko), .bg_in_n(bg_in_n),
        .bg_out_n(bg_out_n), .base_sw(12'h3C1), .am_nonpriv_sel(npriv), .vector_enable(vec_en),
        .intr_ack_request_n(iack_n), .chip_rdata(rdata), .chip_wdata(wdata), .chip_rs(rs), .chip_cs_n(cs_n),
        .periph_read_strobe_n(rd_n), .periph_write_strobe_n(wr_n), .data_driver_enable_n(den_n), .xcvr_en(xen),
        .xcvr_to_vme(xdir), .chip_clk(cclk), .chip_reset(creset), .access_start(start),
        .addr_match_latched(match));
    vst_master_model i_master (.ref_clk(ref_clk), .dtack_oe(dt_oe), .fdtack(fdtack), .d_out(d_out),
        .adr(adr), .strb(strb), .d_in(d_in));
    // shared compare; counts and reports
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // pass-throughs, vector enable, interrupter dtack request, chip clock rate
    task automatic t_misc();
        int n;
        logic c;
        n = 0;
        c = cclk;
        @(posedge ref_clk) #1;
        {bg_in_n, irq_req, vec_en, iack_n, iko_n} = {4'hA, 7'h24, 1'b1, 1'b0, 1'b0};
        repeat (3) @(posedge ref_clk);
        #1;
        chk({bg_out_n, irq_oe, iko}, {4'hA, 7'h24, 1'b0});
        chk({dt_oe, dt_o, irq_o, xen, xdir}, {2'b10, 7'h00, 2'b11});
        {vec_en, iack_n, iko_n} = 3'b011;
        repeat (4) @(posedge ref_clk);
        #1;
        chk({dt_oe, xen, iko}, 3'b001);
        repeat (200) @(posedge ref_clk) if (cclk !== c) begin n++; c = cclk; end
        chk(n >= 15 && n <= 17, 1);
        $display("test misc done");
    endtask
    // read, then a write straight after it inside recovery
    task automatic t_rw();
        logic s;
        logic [15:0] rd;
        i_master.go({12'h3C1, 3'h5}, AM_SUPV, 1, 1, 0, 1);
        i_master.ack(400, s, rd);
        chk({s, rd}, {1'b1, UPPER_FILL, rdata});
        chk({rd_n, cs_n, den_n, d_oe, xen, xdir, rs}, {6'b000111, 3'h5});
        chk(t_go - t_ds >= T_SETUP_NS && t_ack - t_go >= T_ACCESS_NS, 1);
        i_master.stop(0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({rs, match, rd_n, d_oe}, {3'h5, 3'b010});
        npriv = 1'b1;
        i_master.go({12'h3C1, 3'h2}, AM_NONPRIV, 1, 1, 1, 1);
        i_master.ack(400, s, rd);
        chk({s, wdata, wr_n, cs_n, den_n, d_oe, xen, xdir, rs}, {1'b1, 8'hC3, 6'b110010, 3'h2});
        chk(t_go - t_rel >= T_RECOV_NS, 1);
        fork
            i_master.stop(12);
            begin repeat (10) @(posedge ref_clk); #1 chk(dt_oe, 1); end
        join
        chk(dt_oe, 0);
        $display("test read write done");
    endtask
    // wrong base, wrong modifier, long word, iack, then an address-only cycle
    task automatic t_refuse();
        logic s;
        logic [15:0] rd;
        for (int k = 0; k < 5; k++) begin
            i_master.go({(k == 0) ? 12'h3C0 : 12'h3C1, 3'h1}, (k == 1) ? AM_SUPV : AM_NONPRIV,
                        k != 2, k != 3, 0, k != 4);
            i_master.ack(80, s, rd);
            chk({s, rd_n, match}, {2'b01, k == 4});
            i_master.stop(0);
            repeat (3) @(posedge ref_clk);
            #1;
            chk(match, 0);
        end
        $display("test refuse done");
    endtask
    // another slave still holds dtack when we are addressed
    task automatic t_foreign();
        logic s;
        logic [15:0] rd;
        fdtack = 1'b1;
        i_master.go({12'h3C1, 3'h7}, AM_NONPRIV, 1, 1, 0, 1);
        repeat (150) @(posedge ref_clk);
        chk(rd_n, 1);
        #1 fdtack = 1'b0;
        t_free = $realtime;
        i_master.ack(400, s, rd);
        chk(s && t_go - t_free >= T_SETUP_NS, 1);
        i_master.stop(0);
        $display("test foreign done");
    endtask
    initial begin
        #200us;
        err_total++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        chk({creset, rd_n, wr_n, dt_oe, match, bg_out_n}, {5'b11100, BG_RST});
        rst = 1'b0;
        t_misc();
        t_rw();
        t_refuse();
        t_foreign();
        close_out();
    end
endmodule
`default_nettype wire
